// *** rsb_exec.sv ***
`timescale 1ns/10ps
// Operation
// - push places address after the instruction on stack; one cycle, flags kept.
// - relative call is 11011 then 11-bit signed offset; flags untouched.
// - relative call pushes call address plus 2 before adding twice offset.
// - call target is address plus 2 plus twice offset; two cycles.
// - software reset opcode returns all master-clear registers to reset values.
// - interrupt return pops pc and sets high or low irq enable; two cycles.
// - shadow bit set restores accumulator, flags, bank select; clear leaves them.
// - interrupt return leaves pc upper and high latches unchanged.
// - literal return loads constant into accumulator, pops pc; two cycles, no flags.
// - literal return leaves pc high latch unchanged.
module rsb_exec
  import rsb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // instruction from fetch, sampled in the first quarter
  input wire logic [15:0] instr_word,
  // interrupt return selects the low-priority enable when high
  input wire logic irq_ret_low,
  // shadow copies kept by the core
  input wire logic [7:0] accumulator_shadow,
  input wire logic [FLAGS_W-1:0] flags_shadow,
  input wire logic [BANK_W-1:0] bank_select_shadow,
  // core state
  output logic [PC_W-1:0] pc_r,
  output logic [PC_W-1:0] top_of_return_stack,
  output logic [SP_W-1:0] stack_level,
  output logic [7:0] accumulator_r,
  output logic [FLAGS_W-1:0] flags_r,
  output logic [BANK_W-1:0] bank_select_register_r,
  output logic high_priority_irq_enable_r,
  output logic low_priority_irq_enable_r,
  output logic [7:0] pc_high_latch_r,
  output logic [4:0] pc_upper_latch_r,
  // cycle status
  output logic [1:0] phase_r,
  output logic nop_cycle_r,
  output logic sw_reset_r
);

  function automatic rsb_op_e decode(input logic [15:0] w);
    if (w == OPC_PUSH) return OP_PUSH;
    if (w == OPC_RESET) return OP_RESET;
    if (w[15:1] == OPC_RETURN_FROM_INTERRUPT_HI) return OP_RETURN_FROM_INTERRUPT;
    if (w[15:11] == OPC_RELATIVE_SUBROUTINE_CALL_HI) return OP_RELATIVE_SUBROUTINE_CALL;
    if (w[15:8] == OPC_RETURN_WITH_LITERAL_HI) return OP_RETURN_WITH_LITERAL;
    return OP_OTHER;
  endfunction

  function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc,
                                                 input logic [OFF_W-1:0] n);
    logic [PC_W-1:0] twice_n;
    twice_n = {{(PC_W-OFF_W-1){n[OFF_W-1]}}, n, 1'b0};
    return pc + PC_STEP + twice_n;
  endfunction

  rsb_state_e state_r, state_nxt;
  rsb_op_e op_r, op_nxt;
  logic [15:0] word_r, word_nxt;
  logic [1:0] phase_nxt;
  logic [PC_W-1:0] pc_nxt;
  logic [7:0] acc_nxt;
  logic [FLAGS_W-1:0] flags_nxt;
  logic [BANK_W-1:0] bank_nxt;
  logic hi_en_nxt, lo_en_nxt, swr_nxt, nop_nxt;
  logic stk_push, stk_pop, stk_clear;
  logic exec_q2, exec_q4;

  assign exec_q2 = (state_r == ST_EXEC) && (phase_r == Q2);
  assign exec_q4 = (state_r == ST_EXEC) && (phase_r == Q4);

  rsb_stack u_stack (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .push(stk_push),
    .pop(stk_pop),
    .clear(stk_clear),
    .push_data(pc_r + PC_STEP),
    .top_r(top_of_return_stack),
    .sp_r(stack_level)
  );

  // stack strobes: pushes in Q2, pops in Q4
  always_comb begin
    stk_push = exec_q2 && (op_r == OP_PUSH || op_r == OP_RELATIVE_SUBROUTINE_CALL);
    stk_pop = exec_q4 && (op_r == OP_RETURN_FROM_INTERRUPT || op_r == OP_RETURN_WITH_LITERAL);
    stk_clear = exec_q4 && op_r == OP_RESET;
  end

  always_comb begin
    phase_nxt = phase_r + 2'h1;
    state_nxt = state_r;
    op_nxt = op_r;
    word_nxt = word_r;
    pc_nxt = pc_r;
    acc_nxt = accumulator_r;
    flags_nxt = flags_r;
    bank_nxt = bank_select_register_r;
    hi_en_nxt = high_priority_irq_enable_r;
    lo_en_nxt = low_priority_irq_enable_r;
    swr_nxt = 1'b0;
    if (state_r == ST_EXEC && phase_r == Q1) begin
      op_nxt = decode(instr_word);
      word_nxt = instr_word;
    end
    if (phase_r == Q4) begin
      state_nxt = ST_EXEC;
      op_nxt = OP_OTHER;
    end
    if (exec_q4) begin
      case (op_r)
        OP_RELATIVE_SUBROUTINE_CALL: begin
          pc_nxt = rel_target(pc_r, word_r[OFF_W-1:0]);
          state_nxt = ST_NOP;
        end
        OP_RESET: begin
          pc_nxt = PC_RST;
          acc_nxt = ACC_RST;
          flags_nxt = FLAGS_RST;
          bank_nxt = BANK_RST;
          hi_en_nxt = 1'b0;
          lo_en_nxt = 1'b0;
          swr_nxt = 1'b1;
        end
        OP_RETURN_FROM_INTERRUPT: begin
          pc_nxt = top_of_return_stack;
          state_nxt = ST_NOP;
          if (irq_ret_low) begin
            lo_en_nxt = 1'b1;
          end else begin
            hi_en_nxt = 1'b1;
          end
          if (word_r[0]) begin
            acc_nxt = accumulator_shadow;
            flags_nxt = flags_shadow;
            bank_nxt = bank_select_shadow;
          end
        end
        OP_RETURN_WITH_LITERAL: begin
          acc_nxt = word_r[7:0];
          pc_nxt = top_of_return_stack;
          state_nxt = ST_NOP;
        end
        default: begin
          pc_nxt = pc_r + PC_STEP;
        end
      endcase
    end
    nop_nxt = (state_nxt == ST_NOP);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_r <= ST_EXEC;
      op_r <= OP_OTHER;
      word_r <= 16'h0000;
      phase_r <= Q1;
      pc_r <= PC_RST;
      accumulator_r <= ACC_RST;
      flags_r <= FLAGS_RST;
      bank_select_register_r <= BANK_RST;
      high_priority_irq_enable_r <= 1'b0;
      low_priority_irq_enable_r <= 1'b0;
      sw_reset_r <= 1'b0;
      nop_cycle_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      word_r <= word_nxt;
      phase_r <= phase_nxt;
      pc_r <= pc_nxt;
      accumulator_r <= acc_nxt;
      flags_r <= flags_nxt;
      bank_select_register_r <= bank_nxt;
      high_priority_irq_enable_r <= hi_en_nxt;
      low_priority_irq_enable_r <= lo_en_nxt;
      sw_reset_r <= swr_nxt;
      nop_cycle_r <= nop_nxt;
    end
  end

  // nop_cycle_r mirrors state_r but is its own flop, so the port needs no decode

  // latches have no write path here; they hold and are cleared by reset or software reset
  always_ff @(posedge clk_sys) begin
    if (!rst_b || stk_clear) begin
      pc_high_latch_r <= LATCH_RST;
      pc_upper_latch_r <= UPPER_RST;
    end else begin
      pc_high_latch_r <= pc_high_latch_r;
      pc_upper_latch_r <= pc_upper_latch_r;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_push_addr;
    exec_q2 && op_r == OP_PUSH |=> top_of_return_stack == pc_r + PC_STEP ##2 pc_r == $past(pc_r, 3) + PC_STEP && state_r == ST_EXEC;
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("push address wrong");

  property p_call_decode;
    state_r == ST_EXEC && phase_r == Q1 && instr_word[15:11] == 5'h1B |=> op_r == OP_RELATIVE_SUBROUTINE_CALL;
  endproperty
  a_call_decode: assert property (p_call_decode) else $error("call not decoded");

  property p_call_push_first;
    exec_q2 && op_r == OP_RELATIVE_SUBROUTINE_CALL |=> top_of_return_stack == $past(pc_r) + PC_STEP && pc_r == $past(pc_r);
  endproperty
  a_call_push_first: assert property (p_call_push_first) else $error("call push order wrong");

  property p_call_target;
    exec_q4 && op_r == OP_RELATIVE_SUBROUTINE_CALL |=> pc_r == rel_target($past(pc_r), $past(word_r[10:0]))
      && $stable(flags_r) ##0 nop_cycle_r [*4] ##1 !nop_cycle_r;
  endproperty
  a_call_target: assert property (p_call_target) else $error("call target or length wrong");

  property p_sw_reset;
    exec_q4 && op_r == OP_RESET |=> pc_r == PC_RST && accumulator_r == ACC_RST
      && flags_r == FLAGS_RST && !high_priority_irq_enable_r && stack_level == SP_RST && sw_reset_r
      && !low_priority_irq_enable_r && bank_select_register_r == BANK_RST;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset incomplete");

  property p_return_from_interrupt;
    exec_q4 && op_r == OP_RETURN_FROM_INTERRUPT |=> pc_r == $past(top_of_return_stack)
      && ($past(irq_ret_low) ? low_priority_irq_enable_r : high_priority_irq_enable_r);
  endproperty
  a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("interrupt return wrong");

  property p_shadow;
    exec_q4 && op_r == OP_RETURN_FROM_INTERRUPT |=> ($past(word_r[0]) ?
      (accumulator_r == $past(accumulator_shadow) && flags_r == $past(flags_shadow)
       && bank_select_register_r == $past(bank_select_shadow)) :
      ($stable(accumulator_r) && $stable(flags_r) && $stable(bank_select_register_r)));
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow restore wrong");

  property p_latch_return_from_interrupt;
    exec_q4 && op_r == OP_RETURN_FROM_INTERRUPT |=> $stable(pc_high_latch_r) && $stable(pc_upper_latch_r);
  endproperty
  a_latch_return_from_interrupt: assert property (p_latch_return_from_interrupt) else $error("latch changed on return");

  property p_return_with_literal;
    exec_q4 && op_r == OP_RETURN_WITH_LITERAL |=> accumulator_r == $past(word_r[7:0])
      && pc_r == $past(top_of_return_stack) && $stable(flags_r) ##0 nop_cycle_r [*4];
  endproperty
  a_return_with_literal: assert property (p_return_with_literal) else $error("literal return wrong");

  property p_latch_return_with_literal;
    exec_q4 && op_r == OP_RETURN_WITH_LITERAL |=> $stable(pc_high_latch_r);
  endproperty
  a_latch_return_with_literal: assert property (p_latch_return_with_literal) else $error("high latch changed");

  c_call: cover property (exec_q4 && op_r == OP_RELATIVE_SUBROUTINE_CALL);
  c_return_from_interrupt_shadow: cover property (exec_q4 && op_r == OP_RETURN_FROM_INTERRUPT && word_r[0]);
  c_return_with_literal: cover property (exec_q4 && op_r == OP_RETURN_WITH_LITERAL);
  c_reset: cover property (exec_q4 && op_r == OP_RESET);

endmodule

// *** rsb_exec_tb_top.sv ***
`timescale 1ns/10ps
module rsb_exec_tb_top
  import rsb_pkg::*;
;
  logic clk_sys;
  logic rst_b;
  logic [15:0] instr_word;
  logic irq_ret_low;
  logic [7:0] acc_sh;
  logic [FLAGS_W-1:0] flg_sh;
  logic [BANK_W-1:0] bank_sh;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] top_o;
  logic [SP_W-1:0] level_o;
  logic [7:0] acc_o;
  logic [FLAGS_W-1:0] flags_o;
  logic [BANK_W-1:0] bank_o;
  logic hi_o;
  logic lo_o;
  logic [7:0] latch_h_o;
  logic [4:0] latch_u_o;
  logic [1:0] phase_r;
  logic nop_cycle_r;
  logic sw_reset_r;
  // expected state, kept from the instruction semantics alone
  logic [PC_W-1:0] pc_e;
  logic [PC_W-1:0] stk[$];
  logic [7:0] acc_e;
  logic [FLAGS_W-1:0] flg_e;
  logic [BANK_W-1:0] bank_e;
  logic hi_e;
  logic lo_e;
  int fails;
  int n_tests;

  rsb_exec i_rsb_exec (
    .clk_sys(clk_sys), .rst_b(rst_b), .instr_word(instr_word), .irq_ret_low(irq_ret_low),
    .accumulator_shadow(acc_sh), .flags_shadow(flg_sh), .bank_select_shadow(bank_sh),
    .pc_r(pc_r), .top_of_return_stack(top_o), .stack_level(level_o),
    .accumulator_r(acc_o), .flags_r(flags_o), .bank_select_register_r(bank_o),
    .high_priority_irq_enable_r(hi_o), .low_priority_irq_enable_r(lo_o),
    .pc_high_latch_r(latch_h_o), .pc_upper_latch_r(latch_u_o),
    .phase_r(phase_r), .nop_cycle_r(nop_cycle_r), .sw_reset_r(sw_reset_r)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_state();
    logic [PC_W-1:0] top_e;
    top_e = (stk.size() > 0) ? stk[$] : PC_RST;
    chk(32'(pc_r), 32'(pc_e));
    chk(32'(top_o), 32'(top_e));
    chk(32'(level_o), 32'(stk.size()));
    chk(32'(acc_o), 32'(acc_e));
    chk(32'(flags_o), 32'(flg_e));
    chk(32'(bank_o), 32'(bank_e));
    chk(32'(hi_o), 32'(hi_e));
    chk(32'(lo_o), 32'(lo_e));
    // latches have no write path, so any change is a fault
    chk(32'(latch_h_o), 32'(LATCH_RST));
    chk(32'(latch_u_o), 32'(UPPER_RST));
  endtask

  // capture happens at the next edge; results land at the fourth edge
  task automatic exec(input logic [15:0] w);
    instr_word <= w;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  // the held word must be ignored during the flush cycle
  task automatic nop_tail();
    chk(32'(nop_cycle_r), 32'h1);
    repeat (4) @(posedge clk_sys);
    #1;
    chk(32'(nop_cycle_r), 32'h0);
    chk_state();
  endtask

  task automatic t_reset();
    chk_state();
    chk(32'(phase_r), 32'(Q1));
    chk(32'(nop_cycle_r), 32'h0);
    $display("test reset done");
  endtask

  task automatic t_push();
    exec(OPC_PUSH);
    stk.push_back(pc_e + PC_STEP);
    pc_e = pc_e + PC_STEP;
    chk_state();
    chk(32'(nop_cycle_r), 32'h0);
    $display("test push done");
  endtask

  task automatic t_call(input logic [OFF_W-1:0] n);
    exec({OPC_RELATIVE_SUBROUTINE_CALL_HI, n});
    stk.push_back(pc_e + PC_STEP);
    pc_e = pc_e + PC_STEP + (PC_W'($signed(n)) << 1);
    chk_state();
    nop_tail();
    $display("test call %h done", n);
  endtask

  task automatic t_other();
    exec(16'h0000);
    pc_e = pc_e + PC_STEP;
    chk_state();
    $display("test plain step done");
  endtask

  task automatic t_return_with_literal(input logic [7:0] k);
    exec({OPC_RETURN_WITH_LITERAL_HI, k});
    pc_e = stk.pop_back();
    acc_e = k;
    chk_state();
    nop_tail();
    $display("test literal return done");
  endtask

  task automatic t_return_from_interrupt(input logic s, input logic low);
    irq_ret_low <= low;
    exec({OPC_RETURN_FROM_INTERRUPT_HI, s});
    pc_e = stk.pop_back();
    if (low) begin
      lo_e = 1'b1;
    end else begin
      hi_e = 1'b1;
    end
    if (s) begin
      acc_e = acc_sh;
      flg_e = flg_sh;
      bank_e = bank_sh;
    end
    chk_state();
    nop_tail();
    $display("test interrupt return %b done", s);
  endtask

  task automatic t_swreset();
    exec(OPC_RESET);
    stk.delete();
    pc_e = PC_RST;
    acc_e = ACC_RST;
    flg_e = FLAGS_RST;
    bank_e = BANK_RST;
    hi_e = 1'b0;
    lo_e = 1'b0;
    chk_state();
    chk(32'(sw_reset_r), 32'h1);
    @(posedge clk_sys);
    #1;
    chk(32'(sw_reset_r), 32'h0);
    $display("test software reset done");
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // the whole sequence needs about 70 clocks
  initial begin
    repeat (1000) @(posedge clk_sys);
    fails++;
    end_sim();
  end

  initial begin
    fails = 0;
    n_tests = 0;
    rst_b = 1'b0;
    instr_word = 16'h0000;
    irq_ret_low = 1'b0;
    acc_sh = 8'hA5;
    flg_sh = 5'h15;
    bank_sh = 4'hC;
    pc_e = PC_RST;
    acc_e = ACC_RST;
    flg_e = FLAGS_RST;
    bank_e = BANK_RST;
    hi_e = 1'b0;
    lo_e = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    t_reset();
    t_push();
    t_push();
    t_call(11'h3FF);
    t_call(11'h400);
    t_other();
    t_return_with_literal(8'h5A);
    t_return_from_interrupt(1'b0, 1'b1);
    t_return_from_interrupt(1'b1, 1'b0);
    t_return_with_literal(8'h3C);
    t_push();
    t_swreset();
    end_sim();
  end
endmodule

// *** rsb_pkg.sv ***
package rsb_pkg;

  // widths
  localparam int PC_W = 21;
  localparam int STK_DEPTH = 31;
  localparam int SP_W = 5;
  localparam int FLAGS_W = 5;
  localparam int BANK_W = 4;

  // quarter phases of one instruction cycle
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;

  // opcode patterns
  localparam logic [15:0] OPC_PUSH = 16'h0005;
  localparam logic [15:0] OPC_RESET = 16'h00FF;
  localparam logic [14:0] OPC_RETURN_FROM_INTERRUPT_HI = 15'h0008;
  localparam logic [4:0] OPC_RELATIVE_SUBROUTINE_CALL_HI = 5'h1B;
  localparam logic [7:0] OPC_RETURN_WITH_LITERAL_HI = 8'h0C;
  localparam int OFF_W = 11;

  // reset values
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 5'h00;
  localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [4:0] UPPER_RST = 5'h00;
  localparam logic [SP_W-1:0] SP_RST = 5'h00;

  // address step of one instruction word
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  typedef enum logic {ST_EXEC, ST_NOP} rsb_state_e;

  typedef enum logic [2:0] {
    OP_OTHER, OP_PUSH, OP_RELATIVE_SUBROUTINE_CALL, OP_RESET, OP_RETURN_FROM_INTERRUPT, OP_RETURN_WITH_LITERAL
  } rsb_op_e;

endpackage

// *** rsb_stack.sv ***
`timescale 1ns/10ps
module rsb_stack
  import rsb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // control
  input wire logic push,
  input wire logic pop,
  input wire logic clear,
  input wire logic [PC_W-1:0] push_data,
  // state
  output logic [PC_W-1:0] top_r,
  output logic [SP_W-1:0] sp_r
);

  logic [PC_W-1:0] mem [STK_DEPTH];
  logic [PC_W-1:0] top_nxt;
  logic [SP_W-1:0] sp_nxt;

  always_comb begin
    top_nxt = top_r;
    sp_nxt = sp_r;
    if (clear) begin
      top_nxt = PC_RST;
      sp_nxt = SP_RST;
    end else if (push) begin
      top_nxt = push_data;
      // overflow wraps silently from 31 to 0; only the mem write below checks depth
      sp_nxt = sp_r + 5'h01;
    end else if (pop) begin
      top_nxt = (sp_r == SP_RST) ? PC_RST : mem[sp_r - 5'h01];
      sp_nxt = (sp_r == SP_RST) ? SP_RST : sp_r - 5'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      top_r <= PC_RST;
      sp_r <= SP_RST;
    end else begin
      top_r <= top_nxt;
      sp_r <= sp_nxt;
    end
  end

  // older top moves one level down
  always_ff @(posedge clk_sys) begin
    if (rst_b && !clear && push && sp_r < 5'(STK_DEPTH)) begin
      mem[sp_r] <= top_r;
    end
  end

  // a push remembers the top it buried, so the pop straight after it can be checked
  logic [PC_W-1:0] buried_r;
  logic buried_vld_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_b || clear) begin
      buried_vld_r <= 1'b0;
    end else if (push) begin
      buried_vld_r <= 1'b1;
    end else if (pop) begin
      buried_vld_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      buried_r <= top_r;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_push_then_pop;
    buried_vld_r && pop && !push && !clear && sp_r != SP_RST |=> top_r == $past(buried_r);
  endproperty
  a_push_then_pop: assert property (p_push_then_pop) else $error("pop did not restore old top");

endmodule
